// [hcg_defs.svh]
// Constants for the host bus to cipher port glue.
`ifndef HCG_DEFS_SVH
`define HCG_DEFS_SVH
`define HCG_REF_CLK_HZ 100000000
`define HCG_CIPHER_MAX_HZ 4000000
`define HCG_CIPHER_SLOW_MAX_HZ 3000000
`define HCG_WAIT_FAST_HZ 7000000
`define HCG_DIV_DEFAULT 13
`define HCG_WAIT_STATES_DEFAULT 1
`endif

// [hcg_pkg.sv]
// Types for the host bus to cipher port glue.
package hcg_pkg;
  typedef enum logic [1:0] {
    HCG_BUS_IDLE = 2'b00,
    HCG_BUS_FIRST = 2'b01,
    HCG_BUS_WAIT = 2'b10,
    HCG_BUS_DATA = 2'b11
  } hcg_bus_state_type;
  typedef enum logic {
    HCG_SYNC_FORCE_LOW = 1'b0,
    HCG_SYNC_FORCE_HIGH = 1'b1
  } hcg_sync_type;
endpackage

// [hcg_host_clk_div.sv]
// Host clock enable divider producing the emulated host bus clock phases.
`timescale 1ns/1ps
module hcg_host_clk_div #(
  parameter int DIV = 13
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic rise_en,
  output logic fall_en
);
  localparam int CW = $clog2(2 * DIV + 1);
  logic [CW-1:0] cnt_r;
  wire last_w = (cnt_r == CW'(2 * DIV - 1));
  wire half_w = (cnt_r == CW'(DIV - 1));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
    end else begin
      cnt_r <= last_w ? '0 : cnt_r + CW'(1);
      rise_en <= last_w;
      fall_en <= half_w;
    end
  end
endmodule // hcg_host_clk_div

// [hcg_glue.sv]
// Host bus glue driving the multiplexed master port of a cipher processor.
// Summary of operation
// - Control/key select held low, so port runs multiplexed control mode.
// - Port address strobe is the inverse of address latch enable.
// - Minimum mode: decoder gated by I/O indication; chip select only on I/O.
// - Port direction follows transceiver direction, high read, low write.
// - Maximum mode: data strobe when io read or early io write active.
// - Minimum mode: data strobe when read or write strobe low.
// - Data strobe rising edge aligns with cipher clock falling edge.
// - Cipher clock at most 4 MHz, or 3 MHz for slowest part; only the 4 MHz limit is checked.
// - Cipher clock is host clock divided by two.
// - Host clock fall in first bus state forces cipher clock low or high by parity.
// - Same wait-state count for every device access.
// - Above 7 MHz host clock, at least one wait state on every access.
// - Alternatively delay first cipher clock rise after a data strobe.
// - Software mux: address cycle gives only address strobe, data only data.
`timescale 1ns/1ps
`include "hcg_defs.svh"
module hcg_glue
  import hcg_pkg::*;
#(
  parameter int DIV = `HCG_DIV_DEFAULT,
  parameter int WAIT_STATES = `HCG_WAIT_STATES_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic min_max_select,
  input wire logic io_select,
  input wire logic address_latch,
  input wire logic start,
  input wire logic write,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] port_data_in,
  output logic busy,
  output logic done,
  output logic [7:0] rd_data,
  output logic host_clk,
  output logic cipher_clk,
  output logic control_key_select,
  output logic port_address_strobe_n,
  output logic port_chip_select_n,
  output logic port_direction,
  output logic port_data_strobe_n,
  output logic [7:0] port_data_out,
  output logic port_data_oe
);
  import hcg_pkg::*;
  // ----------------------------------------------------------------
  // Host clock phases and limits
  // ----------------------------------------------------------------
  localparam int HOST_HZ = `HCG_REF_CLK_HZ / (2 * DIV);
  localparam int CIPHER_HZ = HOST_HZ / 2;
  // At least one wait state on every access when fast; uniform count keeps parity valid.
  localparam int WAITS = (HOST_HZ > `HCG_WAIT_FAST_HZ && WAIT_STATES < 1) ? 1 : WAIT_STATES;
  localparam hcg_sync_type SYNC = WAITS[0] ? HCG_SYNC_FORCE_HIGH : HCG_SYNC_FORCE_LOW;
  initial begin
    if (CIPHER_HZ > `HCG_CIPHER_MAX_HZ) begin
      $error("Cipher clock too fast");
    end
  end
  logic rise_en;
  logic fall_en;
  hcg_host_clk_div #(.DIV(DIV)) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .rise_en(rise_en),
    .fall_en(fall_en)
  );
  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  logic [7:0] din_s1_r;
  logic [7:0] din_s2_r;
  logic [2:0] mode_s1_r;
  logic [2:0] mode_s2_r;
  always_ff @(posedge ref_clk) begin
    din_s1_r <= port_data_in;
    din_s2_r <= din_s1_r;
    mode_s1_r <= {min_max_select, io_select, address_latch};
    mode_s2_r <= mode_s1_r;
  end
  wire min_mode_w = mode_s2_r[2];
  wire io_cycle_w = mode_s2_r[1];
  wire addr_cycle_w = mode_s2_r[0];
  // ----------------------------------------------------------------
  // Emulated host bus cycle: T1, T2, waits, T3/T4
  // ----------------------------------------------------------------
  hcg_bus_state_type st_r;
  hcg_bus_state_type st_nxt;
  logic [3:0] wcnt_r;
  logic ale_r;
  logic rd_n_r;
  logic wr_n_r;
  logic dtr_r;
  logic cycle_addr_r;
  logic cycle_write_r;
  logic [1:0] sel_r;
  logic [7:0] wdat_r;
  wire take_w = start && !busy && rise_en;
  wire wait_done_w = (wcnt_r == 4'(WAITS));
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      HCG_BUS_IDLE: st_nxt = take_w ? HCG_BUS_FIRST : HCG_BUS_IDLE;
      HCG_BUS_FIRST: st_nxt = rise_en ? HCG_BUS_WAIT : HCG_BUS_FIRST;
      HCG_BUS_WAIT: st_nxt = (rise_en && wait_done_w) ? HCG_BUS_DATA : HCG_BUS_WAIT;
      HCG_BUS_DATA: st_nxt = rise_en ? HCG_BUS_IDLE : HCG_BUS_DATA;
    endcase
  end
  // Strobes active in WAIT (T2..Tw); released at the host clock fall in DATA, i.e. mid T3.
  wire strobe_phase_w = (st_r == HCG_BUS_WAIT);
  wire ale_nxt = (st_nxt == HCG_BUS_FIRST) && take_w;
  wire data_cyc_w = !cycle_addr_r;
  wire rd_n_nxt = !(strobe_phase_w && data_cyc_w && !cycle_write_r);
  wire wr_n_nxt = !(strobe_phase_w && data_cyc_w && cycle_write_r);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= HCG_BUS_IDLE;
      wcnt_r <= '0;
      cycle_addr_r <= 1'b0;
      cycle_write_r <= 1'b0;
      sel_r <= '0;
      wdat_r <= '0;
      dtr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (take_w) begin
        cycle_addr_r <= addr_cycle_w;
        cycle_write_r <= write;
        sel_r <= reg_sel;
        wdat_r <= wr_data;
        dtr_r <= !write;
      end
      if (st_r != HCG_BUS_WAIT) begin
        wcnt_r <= '0;
      end else if (rise_en) begin
        wcnt_r <= wcnt_r + 4'(1);
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ale_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end else begin
      if (take_w) begin
        ale_r <= addr_cycle_w;
      end else if (fall_en) begin
        ale_r <= 1'b0;
      end
      if (rise_en || fall_en) begin
        rd_n_r <= rd_n_nxt;
        wr_n_r <= wr_n_nxt;
      end
    end
  end
  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  // The port strobe is decoded from the command levels taking effect on this edge.
  // A second register stage would make its rising edge trail the cipher clock fall.
  wire rd_n_w = (rise_en || fall_en) ? rd_n_nxt : rd_n_r;
  wire wr_n_w = (rise_en || fall_en) ? wr_n_nxt : wr_n_r;
  wire ior_w = !rd_n_w; // io read command
  wire eiow_w = !wr_n_w; // early io write command
  wire ds_max_w = ior_w || eiow_w;
  wire ds_min_w = !(rd_n_w && wr_n_w);
  wire ds_act_w = min_mode_w ? ds_min_w : ds_max_w;
  wire cs_act_w = min_mode_w ? io_cycle_w : 1'b1;
  wire ds_rise_w = !ds_act_w && !port_data_strobe_n;
  // ----------------------------------------------------------------
  // Cipher clock divider with first-state synchroniser
  // ----------------------------------------------------------------
  // The forced phase stands in for delaying the first cipher rise after a strobe.
  wire t1_end_w = (st_r == HCG_BUS_FIRST) && fall_en;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_clk <= 1'b0;
      cipher_clk <= 1'b0;
      control_key_select <= 1'b0;
      port_address_strobe_n <= 1'b1;
      port_chip_select_n <= 1'b1;
      port_direction <= 1'b0;
      port_data_strobe_n <= 1'b1;
      port_data_out <= '0;
      port_data_oe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rd_data <= '0;
    end else begin
      control_key_select <= 1'b0;
      if (rise_en) begin
        host_clk <= 1'b1;
      end else if (fall_en) begin
        host_clk <= 1'b0;
      end
      if (t1_end_w) begin
        cipher_clk <= (SYNC == HCG_SYNC_FORCE_HIGH);
      end else if (fall_en && host_clk) begin
        // The first fall enable after reset finds the host clock already low; skip it.
        cipher_clk <= !cipher_clk;
      end
      port_address_strobe_n <= !ale_r;
      port_chip_select_n <= !(cs_act_w && (st_nxt != HCG_BUS_IDLE));
      port_direction <= dtr_r;
      port_data_strobe_n <= !ds_act_w;
      // Address cycles put select bits on the muxed lines for the device latch.
      port_data_out <= cycle_addr_r ? {5'h00, sel_r, 1'b0} : wdat_r;
      port_data_oe <= (st_r != HCG_BUS_IDLE) && (cycle_addr_r || cycle_write_r);
      busy <= (st_nxt != HCG_BUS_IDLE);
      done <= (st_r == HCG_BUS_DATA) && rise_en;
      if (ds_rise_w && !cycle_write_r) begin
        rd_data <= din_s2_r;
      end
    end
  end
endmodule // hcg_glue

// [hcg_glue_chk.sv]
// Port timing checker for the host bus to cipher port glue.
`timescale 1ns/1ps
module hcg_glue_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic host_clk,
  input wire logic cipher_clk,
  input wire logic control_key_select,
  input wire logic port_address_strobe_n,
  input wire logic port_chip_select_n,
  input wire logic port_direction,
  input wire logic port_data_strobe_n,
  input wire logic port_data_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ck_low; !control_key_select; endproperty
  a_ck_low: assert property (p_ck_low) else $error("key select high");
  property p_cs_busy; !port_chip_select_n |-> busy; endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("select outside access");
  property p_excl; !port_data_strobe_n |-> port_address_strobe_n; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_dir; !port_data_strobe_n && !$past(port_data_strobe_n) |-> $stable(port_direction);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved in strobe");
  property p_float; !port_data_strobe_n && port_direction |-> !port_data_oe; endproperty
  a_float: assert property (p_float) else $error("bus driven in read");
  property p_sync; $rose(port_data_strobe_n) |-> $fell(cipher_clk); endproperty
  a_sync: assert property (p_sync) else $error("strobe not on clock fall");
  property p_at_host; $changed(cipher_clk) |-> $fell(host_clk); endproperty
  a_at_host: assert property (p_at_host) else $error("cipher edge off host fall");
  property p_rate; $changed(cipher_clk) |=> $stable(cipher_clk)[*3]; endproperty
  a_rate: assert property (p_rate) else $error("cipher clock too fast");
endmodule // hcg_glue_chk
bind hcg_glue hcg_glue_chk u_chk (.ref_clk(ref_clk), .rst(rst), .busy(busy),
  .host_clk(host_clk), .cipher_clk(cipher_clk), .control_key_select(control_key_select),
  .port_address_strobe_n(port_address_strobe_n), .port_chip_select_n(port_chip_select_n),
  .port_direction(port_direction), .port_data_strobe_n(port_data_strobe_n),
  .port_data_oe(port_data_oe));

// [hcg_cipher_model.sv]
// Behavioural cipher port with four selectable byte registers.
`timescale 1ns/1ps
module hcg_cipher_model (
  input wire logic port_address_strobe_n,
  input wire logic port_chip_select_n,
  input wire logic port_direction,
  input wire logic port_data_strobe_n,
  input wire logic [7:0] port_data_out,
  output logic [7:0] port_data_in
);
  logic [7:0] regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0] sel_r = 2'h0;
  logic cs_r = 1'b0;
  logic [7:0] last_r = 8'h00;
  always @(posedge port_address_strobe_n) begin
    sel_r = port_data_out[2:1];
    cs_r = !port_chip_select_n;
  end
  always @(posedge port_data_strobe_n) begin
    if (cs_r && !port_direction) regs[sel_r] = port_data_out;
    if (cs_r && port_direction) last_r = regs[sel_r];
  end
  // A released bus shows the inverse of its last byte, so stale data cannot pass.
  assign port_data_in = (cs_r && port_direction && !port_data_strobe_n) ? regs[sel_r] : ~last_r;
endmodule // hcg_cipher_model

// [test_host_bus_to_cipher_port_glue.sv]
// Self-checking testbench for the host bus to cipher port glue.
`timescale 1ns/1ps
module test_host_bus_to_cipher_port_glue;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic min_max_select = 1'b1;
  logic io_select = 1'b1;
  logic address_latch = 1'b0;
  logic start = 1'b0;
  logic write = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] port_data_in, rd_data, port_data_out;
  logic busy, done, host_clk, cipher_clk, control_key_select, port_data_oe;
  logic port_address_strobe_n, port_chip_select_n, port_direction, port_data_strobe_n;
  int fails = 0;
  int total_checks = 0;
  int as_cnt = 0;
  int ds_cnt = 0;
  hcg_glue #(.DIV(13), .WAIT_STATES(1)) dut (.ref_clk(ref_clk), .rst(rst),
    .min_max_select(min_max_select), .io_select(io_select), .address_latch(address_latch),
    .start(start), .write(write), .reg_sel(reg_sel), .wr_data(wr_data),
    .port_data_in(port_data_in), .busy(busy), .done(done), .rd_data(rd_data),
    .host_clk(host_clk), .cipher_clk(cipher_clk), .control_key_select(control_key_select),
    .port_address_strobe_n(port_address_strobe_n), .port_chip_select_n(port_chip_select_n),
    .port_direction(port_direction), .port_data_strobe_n(port_data_strobe_n),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe));
  hcg_cipher_model u_dev (.port_address_strobe_n(port_address_strobe_n),
    .port_chip_select_n(port_chip_select_n), .port_direction(port_direction),
    .port_data_strobe_n(port_data_strobe_n), .port_data_out(port_data_out),
    .port_data_in(port_data_in));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(negedge port_address_strobe_n) as_cnt++;
  always @(negedge port_data_strobe_n) ds_cnt++;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One host access; the settle wait covers the two-stage input synchronisers.
  task automatic acc(input logic a, input logic w, input logic [1:0] s, input logic [7:0] d);
    int n;
    n = 0;
    address_latch = a;
    write = w;
    reg_sel = s;
    wr_data = d;
    repeat (3) @(negedge ref_clk);
    as_cnt = 0;
    ds_cnt = 0;
    start = 1'b1;
    while (busy !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    start = 1'b0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      $display("FAIL done expected 1 seen 0");
      wrap_up();
    end
    chk("address strobes", {7'h00, a}, as_cnt[7:0]);
    chk("data strobes", {7'h00, !a}, ds_cnt[7:0]);
  endtask
  task automatic t_rw(input logic [7:0] base);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 1'b1, s[1:0], 8'h00);
      acc(1'b0, 1'b1, s[1:0], base + 8'(s));
    end
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 1'b0, s[1:0], 8'h00);
      acc(1'b0, 1'b0, s[1:0], 8'h00);
      chk("read data", base + 8'(s), rd_data);
    end
    $display("test rw done");
  endtask
  task automatic t_io_gate;
    acc(1'b1, 1'b1, 2'h1, 8'h00);
    acc(1'b0, 1'b1, 2'h1, 8'h11);
    io_select = 1'b0;
    acc(1'b1, 1'b1, 2'h1, 8'h00);
    acc(1'b0, 1'b1, 2'h1, 8'h3C);
    io_select = 1'b1;
    acc(1'b1, 1'b0, 2'h1, 8'h00);
    acc(1'b0, 1'b0, 2'h1, 8'h00);
    chk("gated write", 8'h11, rd_data);
    $display("test io gate done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("idle pins", 8'h07, {5'h00, port_address_strobe_n, port_chip_select_n,
      port_data_strobe_n});
    chk("key select", 8'h00, {7'h00, control_key_select});
    t_rw(8'hA0);
    t_io_gate();
    min_max_select = 1'b0;
    t_rw(8'h5C);
    wrap_up();
  end
endmodule // test_host_bus_to_cipher_port_glue
